/* File: hw/plm_pkg.sv */
package plm_pkg;
   // Pattern generator geometry
   localparam int          PLM_REG_W        = 20;
   localparam int          PLM_E1_TAP_A     = 13;
   localparam int          PLM_E1_TAP_B     = 14;
   localparam int          PLM_QRSS_TAP_A   = 16;
   localparam int          PLM_QRSS_TAP_B   = 19;
   localparam int          PLM_QRSS_ZRUN    = 14;
   localparam logic [13:0] PLM_ZRUN_ZERO    = 14'h0000;
   localparam logic        PLM_SEL_E1       = 1'b1;
   // Sync acquisition and loss
   localparam int          PLM_CNT_W        = 7;
   localparam logic [6:0]  PLM_SYNC_MATCHES = 7'h28;
   localparam logic [6:0]  PLM_LOSS_WINDOW  = 7'h40;
   localparam logic [6:0]  PLM_LOSS_ERRORS  = 7'h06;
   localparam logic [6:0]  PLM_CNT_ZERO     = 7'h00;
   localparam logic [6:0]  PLM_CNT_ONE      = 7'h01;
   // Transmit clock stall timing
   localparam int          PLM_CLK_PERIOD_NS = 100;
   localparam int          PLM_TX_STALL_NS   = 5000;
   localparam int          PLM_TX_STALL_CYC  = (PLM_TX_STALL_NS + PLM_CLK_PERIOD_NS - 1)
                                               / PLM_CLK_PERIOD_NS;
   localparam int          PLM_STALL_W       = 8;

   typedef enum logic {
      PLM_HUNT,
      PLM_SYNC
   } plm_state_e;
endpackage : plm_pkg

/* File: hw/plm_tx_stall.sv */
`timescale 1ns/1ps
`default_nettype none
module plm_tx_stall
   import plm_pkg::*;
#(
   parameter int STALL_CYC = PLM_TX_STALL_CYC
) (
   // Clock and reset
   input  wire logic clk,
   input  wire logic rst_n,
   // Monitored clock and result
   input  wire logic transmit_line_clock,
   output logic      tx_clock_loss
);
   localparam logic [PLM_STALL_W-1:0] TERM  = PLM_STALL_W'(STALL_CYC);
   localparam logic [PLM_STALL_W-1:0] ONE   = PLM_STALL_W'(1);
   localparam logic [PLM_STALL_W-1:0] ZERO  = PLM_STALL_W'(0);

   logic                   prev_d, prev_q;
   logic [PLM_STALL_W-1:0] cnt_d,  cnt_q;
   logic                   loss_d, loss_q;

   // Counts master clock cycles since the last level change; saturates at one below terminal
   always_comb begin
      prev_d = transmit_line_clock;
      cnt_d  = cnt_q;
      loss_d = loss_q;
      if (transmit_line_clock != prev_q) begin
         cnt_d  = ZERO;
         loss_d = 1'b0;
      end else if (cnt_q >= TERM - ONE) begin
         loss_d = 1'b1;
      end else begin
         cnt_d = cnt_q + ONE;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         prev_q <= 1'b0;
         cnt_q  <= ZERO;
         loss_q <= 1'b0;
      end else begin
         prev_q <= prev_d;
         cnt_q  <= cnt_d;
         loss_q <= loss_d;
      end
   end

   assign tx_clock_loss = loss_q;
endmodule : plm_tx_stall
`default_nettype wire

/* File: hw/plm_monitor.sv */
// Function
// - The checker hunts received data for the 2^15-1 pattern in E1 mode or QRSS in T1 mode.
// - The pattern error output stays high while unsynchronized and low once synchronized.
// - Each bit error after sync makes a high pulse one line bit long on the error output.
// - With the count enable set, each pattern bit error also feeds the error count registers.
// - With output select 0 the status output follows receive carrier loss.
// - With output select 1 the status output goes high after about 5 us of no transmit clock.
// - In hardware mode the output select is forced to 0, reporting carrier loss.
// - The checker is timed by the recovered clock, or the master clock when signal is absent.
// - The active-low chip reset returns every control bit to zero.
`timescale 1ns/1ps
`default_nettype none
module plm_monitor
   import plm_pkg::*;
#(
   parameter int STALL_CYC = PLM_TX_STALL_CYC
) (
   // Clock and reset
   input  wire logic clk,
   input  wire logic rst_n,
   // Control bits
   input  wire logic hardware_mode,
   input  wire logic line_standard_select,
   input  wire logic pattern_error_count_enable,
   input  wire logic monitor_output_select,
   // Receive line
   input  wire logic rx_bit_en,
   input  wire logic mclk_bit_en,
   input  wire logic rx_data,
   input  wire logic rx_carrier_loss,
   // Transmit clock
   input  wire logic transmit_line_clock,
   // Outputs
   output logic      pattern_error_out,
   output logic      pattern_synced,
   output logic      error_count_inc,
   output logic      line_loss_status
);
   logic                 e1_d, e1_q;
   logic                 cnten_d, cnten_q;
   logic                 osel_d, osel_q;
   logic                 bit_en;
   logic                 tx_clock_loss;

   plm_state_e           state_d, state_q;
   logic [PLM_REG_W-1:0] sr_d, sr_q;
   logic [PLM_CNT_W-1:0] match_d, match_q;
   logic [PLM_CNT_W-1:0] win_d, win_q;
   logic [PLM_CNT_W-1:0] errs_d, errs_q;
   logic                 pulse_d, pulse_q;
   logic                 inc_d, inc_q;
   logic                 peo_d, peo_q;
   logic                 status_d, status_q;
   logic                 synced_d, synced_q;
   logic                 fb, expect_bit, bit_err;

   // Control bits held in flops so chip reset clears them
   always_comb begin
      e1_d    = (line_standard_select == PLM_SEL_E1);
      cnten_d = pattern_error_count_enable;
      osel_d  = monitor_output_select & ~hardware_mode;
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         e1_q    <= 1'b0;
         cnten_q <= 1'b0;
         osel_q  <= 1'b0;
      end else begin
         e1_q    <= e1_d;
         cnten_q <= cnten_d;
         osel_q  <= osel_d;
      end
   end

   // Recovered clock falls back to master clock when line is dead
   assign bit_en = rx_carrier_loss ? mclk_bit_en : rx_bit_en;

   // Prediction from the shift register; QRSS forces a one after a long zero run
   always_comb begin
      if (e1_q) begin
         fb         = sr_q[PLM_E1_TAP_A] ^ sr_q[PLM_E1_TAP_B];
         expect_bit = fb;
      end else begin
         fb         = sr_q[PLM_QRSS_TAP_A] ^ sr_q[PLM_QRSS_TAP_B];
         expect_bit = fb | (sr_q[PLM_QRSS_ZRUN-1:0] == PLM_ZRUN_ZERO);
      end
      bit_err = (expect_bit != rx_data);
   end

   // Hunt is self-synchronising on received data; in sync the register free-runs
   always_comb begin
      state_d = state_q;
      sr_d    = sr_q;
      match_d = match_q;
      win_d   = win_q;
      errs_d  = errs_q;
      pulse_d = pulse_q;
      inc_d   = 1'b0;
      if (bit_en) begin
         pulse_d = 1'b0;
         case (state_q)
            PLM_HUNT: begin
               sr_d    = {sr_q[PLM_REG_W-2:0], rx_data};
               match_d = bit_err ? PLM_CNT_ZERO : match_q + PLM_CNT_ONE;
               if (!bit_err && match_q >= PLM_SYNC_MATCHES - PLM_CNT_ONE) begin
                  state_d = PLM_SYNC;
                  match_d = PLM_CNT_ZERO;
                  win_d   = PLM_CNT_ZERO;
                  errs_d  = PLM_CNT_ZERO;
               end
            end
            PLM_SYNC: begin
               sr_d    = {sr_q[PLM_REG_W-2:0], fb};
               pulse_d = bit_err;
               inc_d   = bit_err & cnten_q;
               errs_d  = errs_q + (bit_err ? PLM_CNT_ONE : PLM_CNT_ZERO);
               win_d   = win_q + PLM_CNT_ONE;
               // Too many errors in a window means the pattern is gone
               if (errs_d >= PLM_LOSS_ERRORS) begin
                  state_d = PLM_HUNT;
                  match_d = PLM_CNT_ZERO;
               end else if (win_q >= PLM_LOSS_WINDOW - PLM_CNT_ONE) begin
                  win_d  = PLM_CNT_ZERO;
                  errs_d = PLM_CNT_ZERO;
               end
            end
            default: state_d = PLM_HUNT;
         endcase
      end
      peo_d    = (state_d != PLM_SYNC) | pulse_d;
      // Sync flag registered so the port comes straight from a flop
      synced_d = (state_d == PLM_SYNC);
      status_d = osel_q ? tx_clock_loss : rx_carrier_loss;
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         state_q  <= PLM_HUNT;
         sr_q     <= '0;
         match_q  <= PLM_CNT_ZERO;
         win_q    <= PLM_CNT_ZERO;
         errs_q   <= PLM_CNT_ZERO;
         pulse_q  <= 1'b0;
         inc_q    <= 1'b0;
         peo_q    <= 1'b1;
         status_q <= 1'b0;
         synced_q <= 1'b0;
      end else begin
         state_q  <= state_d;
         sr_q     <= sr_d;
         match_q  <= match_d;
         win_q    <= win_d;
         errs_q   <= errs_d;
         pulse_q  <= pulse_d;
         inc_q    <= inc_d;
         peo_q    <= peo_d;
         status_q <= status_d;
         synced_q <= synced_d;
      end
   end

   plm_tx_stall #(
      .STALL_CYC (STALL_CYC)
   ) u_tx_stall (
      .clk                 (clk),
      .rst_n               (rst_n),
      .transmit_line_clock (transmit_line_clock),
      .tx_clock_loss       (tx_clock_loss)
   );

   assign pattern_error_out = peo_q;
   assign pattern_synced    = synced_q;
   assign error_count_inc   = inc_q;
   assign line_loss_status  = status_q;
endmodule : plm_monitor
`default_nettype wire

/* File: verification/plm_line_src.sv */
`timescale 1ns/1ps
`default_nettype none
module plm_line_src (
   // Clock, error request and QRSS pattern select
   input  wire logic clk,
   input  wire logic inject,
   input  wire logic qrss,
   // Line bits
   output logic      bit_en  = 1'b0,
   output logic      bit_out = 1'b0
);
   logic [14:0] lfsr_q = 15'h7FFF;
   logic [1:0]  div_q  = 2'h0;
   logic [19:0] q_q    = 20'hFFFFF;
   wire logic   q_fb   = q_q[16] ^ q_q[19];
   // QRSS forces a one on the line after 14 zeros; the register itself runs unforced
   wire logic   q_bit  = q_fb | (q_q[13:0] == 14'h0000);
   // Inject flips the sent bit only, so the source itself never drifts
   always @(posedge clk) begin
      div_q  <= div_q + 2'h1;
      bit_en <= div_q == 2'h3;
      if (div_q == 2'h3) begin
         bit_out <= (qrss ? q_bit : (lfsr_q[14] ^ lfsr_q[13])) ^ inject;
         lfsr_q  <= {lfsr_q[13:0], lfsr_q[14] ^ lfsr_q[13]};
         q_q     <= {q_q[18:0], q_fb};
      end
   end
endmodule : plm_line_src
`default_nettype wire

/* File: verification/plm_monitor_sva.sv */
`timescale 1ns/1ps
`default_nettype none
module plm_monitor_sva #(parameter int STALL_CYC = 5) (
   input wire logic clk, rst_n, hardware_mode, monitor_output_select, rx_bit_en, mclk_bit_en,
   input wire logic rx_carrier_loss, transmit_line_clock, pattern_error_out, pattern_synced,
   input wire logic error_count_inc, line_loss_status
);
   logic       tx_q;
   logic [7:0] st_q, st_d;
   wire logic  be = rx_carrier_loss ? mclk_bit_en : rx_bit_en;
   wire logic  tx_sel = monitor_output_select && !hardware_mode;
   // Cycles since the transmit clock last moved
   always_comb st_d = (transmit_line_clock != tx_q) ? 8'h00 : st_q + {7'h00, st_q != 8'hFF};
   always_ff @(posedge clk) begin
      tx_q <= transmit_line_clock;
      st_q <= rst_n ? st_d : 8'h00;
   end
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   sequence s_lost; (!monitor_output_select && rx_carrier_loss)[*3]; endsequence
   sequence s_tx; tx_sel[*3]; endsequence
   AST_RESET:
      assert property (disable iff (1'b0) !rst_n |=> pattern_error_out && !pattern_synced
         && !error_count_inc && !line_loss_status) else $error("reset values");
   AST_HUNT_HIGH:
      assert property (!pattern_synced && !$past(pattern_synced) |-> pattern_error_out)
         else $error("hunt low");
   AST_PULSE_HOLD:
      assert property (pattern_synced && !be |=> $stable(pattern_error_out)) else $error("hold");
   AST_INC_ON_BIT:
      assert property (!be |=> !error_count_inc) else $error("count without bit");
   AST_INC_GATED:
      assert property (error_count_inc |-> pattern_error_out && $past(pattern_synced))
         else $error("count out of sync");
   AST_CARRIER_LOSS:
      assert property (s_lost |=> line_loss_status) else $error("carrier loss");
   AST_HW_MODE:
      assert property ((hardware_mode && rx_carrier_loss)[*3] |=> line_loss_status)
         else $error("hardware mode");
   AST_STALL_HIGH:
      assert property (s_tx ##0 st_q > STALL_CYC + 3 |-> line_loss_status) else $error("stall");
   AST_STALL_LOW:
      assert property (s_tx ##0 st_q == 8'h02 |-> !line_loss_status) else $error("early");
endmodule : plm_monitor_sva
bind plm_monitor plm_monitor_sva #(.STALL_CYC(STALL_CYC)) u_sva (.*);
`default_nettype wire

/* File: verification/plm_monitor_test.sv */
`timescale 1ns/1ps
`default_nettype none
module plm_monitor_test;
   import plm_pkg::*;
   localparam int STALL = 5;
   logic clk = 1'b0, rst_n = 1'b0, hardware_mode = 1'b0, line_standard_select = 1'b0;
   logic pattern_error_count_enable = 1'b0, monitor_output_select = 1'b0, inj = 1'b0;
   logic rx_carrier_loss = 1'b0, transmit_line_clock = 1'b0, inc_seen = 1'b0;
   logic qrss = 1'b0, pulse_seen = 1'b0;
   wire logic rx_bit_en, rx_data, pattern_error_out, pattern_synced, error_count_inc;
   wire logic line_loss_status;
   wire logic mclk_bit_en = rx_bit_en;
   int seed = 32'h86b8;
   int bad_count = 0;
   int checked = 0;
   int cyc = 0;
   always #50 clk = ~clk;
   plm_line_src u_src (.clk(clk), .inject(inj), .qrss(qrss), .bit_en(rx_bit_en),
                       .bit_out(rx_data));
   plm_monitor #(.STALL_CYC(STALL)) u_dut (.*);
   task automatic chk(input logic got, input logic exp);
      checked++;
      if (got !== exp) begin
         bad_count++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic wrap_up;
      $display("bad_count %0d checked %0d", bad_count, checked);
      if (bad_count == 0 && checked > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : wrap_up
   task automatic wait_n(input int n);
      repeat (n) @(negedge clk);
   endtask : wait_n
   // Held over exactly one source strobe, so one bit is corrupted
   task automatic send_error;
      inj = 1'b1;
      wait_n(4);
      inj = 1'b0;
      wait_n(12);
   endtask : send_error
   always @(posedge clk) begin
      cyc++;
      if (error_count_inc === 1'b1)
         inc_seen <= 1'b1;
      if (pattern_synced === 1'b1 && pattern_error_out === 1'b1)
         pulse_seen <= 1'b1;
      if (cyc == 5000) begin
         bad_count++;
         wrap_up;
      end
   end
   initial begin
      wait_n(6);
      chk(pattern_error_out, 1'b1);
      chk(line_loss_status, 1'b0);
      rst_n = 1'b1;
      line_standard_select = PLM_SEL_E1;
      pattern_error_count_enable = 1'b1;
      repeat (600) if (pattern_synced !== 1'b1) @(negedge clk);
      chk(pattern_synced, 1'b1);
      chk(pattern_error_out, 1'b0);
      pulse_seen = 1'b0;
      wait_n(40);
      chk(pulse_seen, 1'b0);
      inc_seen = 1'b0;
      send_error;
      chk(inc_seen, 1'b1);
      chk(pulse_seen, 1'b1);
      chk(pattern_synced, 1'b1);
      pattern_error_count_enable = 1'b0;
      inc_seen = 1'b0;
      send_error;
      chk(inc_seen, 1'b0);
      repeat (40) begin
         inj = 1'($random(seed));
         wait_n(4);
      end
      inj = 1'b0;
      wait_n(2);
      chk(pattern_synced, 1'b0);
      chk(pattern_error_out, 1'b1);
      rx_carrier_loss = 1'b1;
      wait_n(4);
      chk(line_loss_status, 1'b1);
      rx_carrier_loss = 1'b0;
      wait_n(4);
      chk(line_loss_status, 1'b0);
      monitor_output_select = 1'b1;
      repeat (20) begin
         transmit_line_clock = 1'($random(seed));
         wait_n(1);
      end
      transmit_line_clock = ~transmit_line_clock;
      wait_n(3);
      chk(line_loss_status, 1'b0);
      wait_n(STALL + 6);
      chk(line_loss_status, 1'b1);
      hardware_mode = 1'b1;
      wait_n(4);
      chk(line_loss_status, 1'b0);
      rx_carrier_loss = 1'b1;
      wait_n(4);
      chk(line_loss_status, 1'b1);
      // T1 phase: the checker must find the QRSS pattern instead
      line_standard_select = ~PLM_SEL_E1;
      qrss = 1'b1;
      wait_n(8);
      repeat (600) if (pattern_synced !== 1'b1) @(negedge clk);
      chk(pattern_synced, 1'b1);
      chk(pattern_error_out, 1'b0);
      wrap_up;
   end
endmodule : plm_monitor_test
`default_nettype wire
